// file: verilog/rtc_clock_correction_int_out.sv
// Clock correction and first interrupt pin minute and power-on outputs
//
// What this block does
// - Minute mode 2 drives first pin low 7.9 ms at each minute carry while the power-on flag is clear.
// - Minute carry and pulse may wait up to 0.5 s during time reads.
// - Seconds write restarts the second, moving the next pulse.
// - Minute mode 2 and power-on 1 Hz appear only on first pin.
// - Power-on sets the power-on flag, status bit 0.
// - While power-on flag is set, first pin shows 1 Hz pulse.
// - Correction alters divider counts, never the oscillator.
// - Correction every 20 s with bit 0 clear, 60 s with it set.
// - Step is 3.052 ppm or 1.017 ppm by interval.
// - Range -195.3..+192.2 ppm or -65.1..+64.1 ppm.
// - Setting sits in bits 7..1, bit 7 least significant.
// - Setting is two's complement step count from -64 to +63.
// - One 1 Hz period in 20 or 60 differs while correcting.
// - The 32.768 kHz output is untouched by correction.
`timescale 1ns/1ps
`include "rtc_map.svh"
module rtc_clock_correction_int_out #(
  parameter int CLK_HZ        = 1000000000 / `CLK_PERIOD_NS,
  parameter int TICKS_PER_SEC = `OSC_HZ,
  parameter int PULSE_CYCLES  = `MP2_PULSE_NS / `CLK_PERIOD_NS
) (
  input  wire logic            clk_sys_i,                   // System clock
  input  wire logic            srst_i,                      // Sync reset
  input  wire rtc_pkg::wb_req_t wb_req_i,                   // Bus request
  output rtc_pkg::wb_rsp_t     wb_rsp_o,                    // Bus answer
  input  wire logic            interrupt_out_first_i,       // First pin level
  output logic                 interrupt_out_first_o,       // First pin value
  output logic                 interrupt_out_first_oe_n_o,  // First pin drive
  input  wire logic            interrupt_out_second_i,      // Second pin level
  output logic                 interrupt_out_second_o,      // Second pin value
  output logic                 interrupt_out_second_oe_n_o, // Second pin drive
  output logic                 osc_tick_o                   // 32.768 kHz tick
);
  import rtc_pkg::*;

  localparam int          HOLD_TICKS_I = TICKS_PER_SEC * `HOLD_MAX_MS / 1000;
  localparam logic [15:0] HOLD_TICKS   = 16'(HOLD_TICKS_I);
  localparam logic [19:0] PULSE_LAST   = 20'(PULSE_CYCLES - 1);
  localparam logic [5:0]  SEC_LAST     = 6'(`SEC_PER_MIN - 1);
  localparam logic [7:0]  SEC_MAX      = 8'(`SEC_PER_MIN - 1);

  localparam top_state_t ST_RST = '{
    ack:    1'b0,
    rdat:   32'h0,
    adj:    `ADJ_RST,
    mp2_en: 1'b0,
    hold:   1'b0,
    pof:    1'b1,
    sec:    6'h0,
    pend:   1'b0,
    hcnt:   16'h0,
    mp:     MP_OFF,
    pcnt:   20'h0,
    interrupt_out_first:   1'b0
  };

  top_state_t st;
  top_state_t next_st;

  logic       sec_tick;
  logic       low_phase;
  logic       osc_tick;
  logic       bus_acc;
  logic       bus_wr;
  logic       sec_wr;
  logic       raw_carry;
  logic       waiting;
  logic       hold_max;
  logic       fire;
  logic [31:0] rd_mux;

  ////////////////////////////////////////////////////////////////////
  // Divider chain with correction
  rtc_divider #(
    .CLK_HZ        (CLK_HZ),
    .TICKS_PER_SEC (TICKS_PER_SEC)
  ) u_div (
    .clk_sys_i   (clk_sys_i),
    .srst_i      (srst_i),
    .adj_i       (st.adj),
    .restart_i   (sec_wr),
    .osc_tick_o  (osc_tick),
    .sec_tick_o  (sec_tick),
    .low_phase_o (low_phase)
  );

  ////////////////////////////////////////////////////////////////////
  // Bus decode
  assign bus_acc = wb_req_i.cyc && wb_req_i.stb && !st.ack;
  assign bus_wr  = bus_acc && wb_req_i.we && wb_req_i.sel[0];
  assign sec_wr  = bus_wr && (wb_req_i.adr == `ADR_SEC);

  always_comb begin
    case (wb_req_i.adr)
      `ADR_ADJ: begin
        rd_mux = {24'h0, st.adj};
      end
      `ADR_CTRL: begin
        rd_mux = {30'h0, st.hold, st.mp2_en};
      end
      `ADR_STAT: begin
        rd_mux = {16'h0, 8'(adj_steps(st.adj)), 4'h0,
                  interrupt_out_second_i, interrupt_out_first_i,
                  st.pend, st.pof};
      end
      `ADR_SEC: begin
        rd_mux = {26'h0, st.sec};
      end
      default: begin
        rd_mux = 32'h0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Minute carry with read postponement
  assign raw_carry = sec_tick && (st.sec == SEC_LAST) && !sec_wr;
  assign waiting   = raw_carry || st.pend;
  assign hold_max  = st.hcnt >= HOLD_TICKS;
  // carry waits while time is read, for at most HOLD_TICKS osc ticks
  assign fire      = waiting && (!st.hold || hold_max);

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st     = st;
    next_st.ack = 1'b0;

    if (bus_acc) begin
      next_st.ack  = 1'b1;
      next_st.rdat = wb_req_i.we ? 32'h0 : rd_mux;
    end

    if (bus_wr) begin
      case (wb_req_i.adr)
        `ADR_ADJ: begin
          next_st.adj = wb_req_i.dat[7:0];
        end
        `ADR_CTRL: begin
          next_st.mp2_en = wb_req_i.dat[`CTRL_MP2_BIT];
          next_st.hold   = wb_req_i.dat[`CTRL_HOLD_BIT];
        end
        `ADR_STAT: begin
          if (wb_req_i.dat[`STAT_POF_BIT]) begin
            next_st.pof = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    if (sec_wr) begin
      if (wb_req_i.dat[7:0] > SEC_MAX) begin
        next_st.sec = 6'h0;
      end else begin
        next_st.sec = wb_req_i.dat[5:0];
      end
    end else if (sec_tick) begin
      if (st.sec == SEC_LAST) begin
        next_st.sec = 6'h0;
      end else begin
        next_st.sec = st.sec + 6'd1;
      end
    end

    next_st.pend = waiting && !fire;
    if (!next_st.pend) begin
      next_st.hcnt = 16'h0;
    end else if (osc_tick) begin
      next_st.hcnt = st.hcnt + 16'd1;
    end

    case (st.mp)
      MP_OFF: begin
        next_st.pcnt = 20'h0;
        if (st.mp2_en) begin
          next_st.mp = MP_WAIT;
        end
      end
      MP_WAIT: begin
        if (!st.mp2_en) begin
          next_st.mp = MP_OFF;
        end else if (fire) begin
          next_st.mp   = MP_LOW;
          next_st.pcnt = 20'h0;
        end
      end
      MP_LOW: begin
        if (!st.mp2_en) begin
          next_st.mp = MP_OFF;
        end else if (st.pcnt >= PULSE_LAST) begin
          next_st.mp = MP_WAIT;
        end else begin
          next_st.pcnt = st.pcnt + 20'd1;
        end
      end
      default: begin
        next_st.mp = MP_OFF;
      end
    endcase

    if (st.pof) begin
      next_st.interrupt_out_first = low_phase;
    end else begin
      next_st.interrupt_out_first = st.mp == MP_LOW;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // flag set by power-on reset
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      st <= ST_RST;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs
  assign wb_rsp_o.ack = st.ack;
  assign wb_rsp_o.dat = st.rdat;

  assign interrupt_out_first_o      = 1'b0;
  assign interrupt_out_first_oe_n_o = !st.interrupt_out_first;

  // second pin never carries these functions
  assign interrupt_out_second_o      = 1'b0;
  assign interrupt_out_second_oe_n_o = 1'b1;

  assign osc_tick_o = osc_tick;

  ////////////////////////////////////////////////////////////////////
  // Checks
  AST_MP2_START: assert property (
    @(posedge clk_sys_i) disable iff (srst_i)
    (st.mp == MP_WAIT && st.mp2_en && fire && !st.pof)
      |-> ##2 !interrupt_out_first_oe_n_o)
    else $error("minute pulse did not start on carry");

  AST_MP2_WIDTH: assert property (
    @(posedge clk_sys_i) disable iff (srst_i)
    (st.mp == MP_LOW && st.pcnt >= PULSE_LAST)
      |=> st.mp != MP_LOW)
    else $error("minute pulse longer than 7.9 ms");

  AST_MP2_COUNT: assert property (
    @(posedge clk_sys_i) disable iff (srst_i)
    $rose(st.mp == MP_LOW) |-> st.pcnt == 20'h0)
    else $error("minute pulse count not cleared");

  AST_HOLD_LIMIT: assert property (
    @(posedge clk_sys_i) disable iff (srst_i)
    st.pend |-> st.hcnt <= HOLD_TICKS)
    else $error("carry held beyond half a second");

  AST_HOLD_RELEASE: assert property (
    @(posedge clk_sys_i) disable iff (srst_i)
    (st.pend && !st.hold) |=> !st.pend)
    else $error("carry stayed pending without read hold");

  AST_SEC_RESTART: assert property (
    @(posedge clk_sys_i) disable iff (srst_i)
    (sec_wr && wb_req_i.dat[7:0] <= SEC_MAX)
      |=> st.sec == $past(wb_req_i.dat[5:0]))
    else $error("seconds write not loaded");

  AST_SECOND_PIN_IDLE: assert property (
    @(posedge clk_sys_i) disable iff (srst_i)
    interrupt_out_second_oe_n_o == 1'b1)
    else $error("second pin driven");

  AST_POF_AT_RESET: assert property (
    @(posedge clk_sys_i) disable iff (srst_i)
    $past(srst_i) |-> st.pof)
    else $error("power-on flag not set after reset");

  AST_POF_1HZ: assert property (
    @(posedge clk_sys_i) disable iff (srst_i)
    (st.pof && low_phase) |=> !interrupt_out_first_oe_n_o)
    else $error("power-on 1 Hz low phase missing");

  AST_POF_HIGH: assert property (
    @(posedge clk_sys_i) disable iff (srst_i)
    (st.pof && !low_phase) |=> interrupt_out_first_oe_n_o)
    else $error("power-on 1 Hz high phase missing");

  AST_STEP_DECODE: assert property (
    @(posedge clk_sys_i) disable iff (srst_i)
    (st.adj[7:1] == 7'h01) |-> adj_steps(st.adj) == -8'sd64)
    else $error("setting decode wrong at most negative");

endmodule : rtc_clock_correction_int_out

// file: verilog/rtc_map.svh
// Register offsets, field positions, reset values and timing figures
`ifndef RTC_MAP_SVH
`define RTC_MAP_SVH
`define ADR_ADJ        8'h00
`define ADR_CTRL       8'h04
`define ADR_STAT       8'h08
`define ADR_SEC        8'h0c
`define CTRL_MP2_BIT   0
`define CTRL_HOLD_BIT  1
`define STAT_POF_BIT   0
`define ADJ_RES_BIT    0
`define ADJ_RST        8'h00
`define CLK_PERIOD_NS  8
`define OSC_HZ         32768
`define MP2_PULSE_NS   7900000
`define HOLD_MAX_MS    500
`define SHORT_INTV_S   20
`define LONG_INTV_S    60
`define SEC_PER_MIN    60
`define STEP_TICKS     2
`endif

// file: verilog/rtc_pkg.sv
// Types and setting decode shared by the clock block
package rtc_pkg;

  typedef enum logic [1:0] {
    MP_OFF  = 2'b00,
    MP_WAIT = 2'b01,
    MP_LOW  = 2'b10
  } mp_state_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_t;

  typedef struct packed {
    logic [26:0]        acc;
    logic [16:0]        sub;
    logic [5:0]         intv;
    logic signed [7:0]  steps;
    logic               long_intv;
    logic               osc;
    logic               sec;
    logic               low;
  } div_state_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdat;
    logic [7:0]  adj;
    logic        mp2_en;
    logic        hold;
    logic        pof;
    logic [5:0]  sec;
    logic        pend;
    logic [15:0] hcnt;
    mp_state_t   mp;
    logic [19:0] pcnt;
    logic        interrupt_out_first;
  } top_state_t;

  // Bits 7..1 hold a reversed two's complement step count
  function automatic logic signed [7:0] adj_steps(input logic [7:0] setting);
    logic [6:0] v;
    v = '0;
    for (int i = 0; i < 7; i++) begin
      v[i] = setting[7-i];
    end
    return {v[6], v};
  endfunction : adj_steps

endpackage : rtc_pkg

// file: verilog/rtc_divider.sv
// Oscillator tick and corrected one-second divider chain
`timescale 1ns/1ps
`include "rtc_map.svh"
module rtc_divider #(
  parameter int CLK_HZ        = 125000000,
  parameter int TICKS_PER_SEC = `OSC_HZ
) (
  input  wire logic       clk_sys_i,   // System clock
  input  wire logic       srst_i,      // Sync reset
  input  wire logic [7:0] adj_i,       // Correction setting
  input  wire logic       restart_i,   // Restart the second
  output logic            osc_tick_o,  // Uncorrected osc tick
  output logic            sec_tick_o,  // Corrected second pulse
  output logic            low_phase_o  // First half of second
);
  import rtc_pkg::*;

  localparam logic [26:0] ACC_STEP = 27'(`OSC_HZ);
  localparam logic [26:0] ACC_WRAP = 27'(CLK_HZ);
  localparam logic [16:0] NOM      = 17'(TICKS_PER_SEC);
  localparam logic [16:0] HALF     = 17'(TICKS_PER_SEC / 2);
  localparam logic [5:0]  LAST_S   = 6'(`SHORT_INTV_S - 1);
  localparam logic [5:0]  LAST_L   = 6'(`LONG_INTV_S - 1);

  div_state_t        st;
  div_state_t        next_st;
  logic [26:0]       sum;
  logic              last;
  logic signed [16:0] delta;
  logic [16:0]       len;

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st     = st;
    next_st.osc = 1'b0;
    next_st.sec = 1'b0;
    sum         = st.acc + ACC_STEP;
    last        = st.intv == (st.long_intv ? LAST_L : LAST_S);
    delta       = 17'(st.steps);
    // two ticks per step, last second only
    len = last ? NOM - 17'(delta * `STEP_TICKS) : NOM;
    if (sum >= ACC_WRAP) begin
      next_st.acc = sum - ACC_WRAP;
      next_st.osc = 1'b1;
    end else begin
      next_st.acc = sum;
    end
    if (restart_i) begin
      next_st.sub = '0;
    end else if (st.osc) begin
      if (st.sub >= len - 17'd1) begin
        next_st.sub = '0;
        next_st.sec = 1'b1;
        if (last) begin
          next_st.intv      = '0;
          next_st.steps     = adj_steps(adj_i);
          next_st.long_intv = adj_i[`ADJ_RES_BIT];
        end else begin
          next_st.intv = st.intv + 6'd1;
        end
      end else begin
        next_st.sub = st.sub + 17'd1;
      end
    end
    next_st.low = next_st.sub < HALF;
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign osc_tick_o  = st.osc;
  assign sec_tick_o  = st.sec;
  assign low_phase_o = st.low;

  ////////////////////////////////////////////////////////////////////
  AST_OSC_SPACING: assert property (
    @(posedge clk_sys_i) disable iff (srst_i) st.osc |=> !st.osc)
    else $error("oscillator tick lasted two cycles");
  AST_CHAIN_IDLE: assert property (
    @(posedge clk_sys_i) disable iff (srst_i)
    (!st.osc && !restart_i) |=> $stable(st.sub))
    else $error("divider moved without oscillator tick");
  AST_SHORT_INTV: assert property (
    @(posedge clk_sys_i) disable iff (srst_i) !st.long_intv |-> st.intv <= LAST_S)
    else $error("20 second interval overran");
  AST_PLAIN_SECOND: assert property (
    @(posedge clk_sys_i) disable iff (srst_i) !last |-> len == NOM)
    else $error("uncorrected second has wrong length");
  AST_RANGE: assert property (
    @(posedge clk_sys_i) disable iff (srst_i)
    len >= NOM - 17'd126 && len <= NOM + 17'd128)
    else $error("corrected second out of range");
  AST_SNAP_BOUNDARY: assert property (
    @(posedge clk_sys_i) disable iff (srst_i)
    !(st.osc && last && !restart_i) |=> $stable(st.steps))
    else $error("setting taken inside an interval");

endmodule : rtc_divider

// file: test/rtc_host_pins.sv
// Host side pull-ups resolving the two open-drain interrupt wires
`timescale 1ns/1ps
module rtc_host_pins (
  input  wire logic first_o_i,      // Device first pin value
  input  wire logic first_oe_n_i,   // Device first pin drive
  input  wire logic second_o_i,     // Device second pin value
  input  wire logic second_oe_n_i,  // Device second pin drive
  output logic      first_lvl_o,    // First wire level
  output logic      second_lvl_o    // Second wire level
);
  assign first_lvl_o  = first_oe_n_i ? 1'b1 : first_o_i;
  assign second_lvl_o = second_oe_n_i ? 1'b1 : second_o_i;
endmodule : rtc_host_pins

// file: test/tb_top.sv
// Self-checking bench for clock correction and first pin outputs
`timescale 1ns/1ps
`include "rtc_map.svh"
module tb_top;
  import rtc_pkg::*;
  localparam int TPS = 260;
  localparam int CPS = TPS * 4;
  localparam int PW  = 50;
  typedef struct packed {logic [31:0] val; logic [31:0] msk;} rd_note_t;
  logic        clk_sys_i;
  logic        srst_i;
  wb_req_t     wb_req;
  wb_rsp_t     wb_rsp;
  logic        first_o, first_oe_n, second_o, second_oe_n;
  logic        first_lvl, second_lvl, osc_tick;
  rd_note_t    exp_q[$];
  int          mismatches = 0;
  int          n_tests = 0;
  int          cyc_cnt = 0;
  int          osc_gap = 0;
  logic [31:0] rng = 32'hd4c2;

  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  rtc_clock_correction_int_out #(
    .CLK_HZ(4 * `OSC_HZ), .TICKS_PER_SEC(TPS), .PULSE_CYCLES(PW)
  ) u_dut (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .wb_req_i(wb_req), .wb_rsp_o(wb_rsp),
    .interrupt_out_first_i(first_lvl), .interrupt_out_first_o(first_o),
    .interrupt_out_first_oe_n_o(first_oe_n), .interrupt_out_second_i(second_lvl),
    .interrupt_out_second_o(second_o), .interrupt_out_second_oe_n_o(second_oe_n),
    .osc_tick_o(osc_tick)
  );
  rtc_host_pins u_host (
    .first_o_i(first_o), .first_oe_n_i(first_oe_n), .second_o_i(second_o),
    .second_oe_n_i(second_oe_n), .first_lvl_o(first_lvl), .second_lvl_o(second_lvl)
  );

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : xs

  function automatic logic [7:0] pack_set(input logic [6:0] v, input logic res);
    logic [7:0] b;
    b[0] = res;
    for (int i = 0; i < 7; i++) b[7-i] = v[i];
    return b;
  endfunction : pack_set

  function automatic logic [7:0] steps_of(input logic [7:0] b);
    logic [6:0] v;
    for (int i = 0; i < 7; i++) v[i] = b[7-i];
    return {v[6], v};
  endfunction : steps_of

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic chk_rng(input int got, input int lo, input int hi, input string what);
    n_tests++;
    if (got < lo || got > hi) begin
      mismatches++;
      $display("ERROR %0t %s got %0d exp %0d..%0d", $time, what, got, lo, hi);
    end
  endtask : chk_rng

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                    input logic [31:0] msk = '0);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    if (!we) exp_q.push_back({dat, msk});
    wb_req <= {1'b1, 1'b1, we, 4'hf, adr, we ? dat : 32'h0};
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (wb_rsp.ack !== 1'b1);
    chk(n, 2, "ack latency");
    wb_req <= '0;
    @(posedge clk_sys_i);
  endtask : wb

  task automatic until_lvl(input logic lvl, input int lim, output int n);
    n = 0;
    while (first_lvl !== lvl && n < lim) begin
      @(posedge clk_sys_i);
      n++;
    end
  endtask : until_lvl

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys_i) begin
    rd_note_t nt;
    if (wb_rsp.ack === 1'b1 && wb_req.we === 1'b0 && exp_q.size() > 0) begin
      nt = exp_q.pop_front();
      chk(wb_rsp.dat & nt.msk, nt.val & nt.msk, "read data");
    end
  end

  always @(posedge clk_sys_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (!srst_i && {second_o, second_oe_n} !== 2'b01) begin
      chk({second_o, second_oe_n}, 2'b01, "second pin");
    end
    if (!srst_i && osc_tick === 1'b1) begin
      if (osc_gap != 0) chk(osc_gap, 4, "osc tick gap");
      osc_gap <= 1;
    end else if (osc_gap != 0) begin
      osc_gap <= osc_gap + 1;
    end
    if (cyc_cnt == 90000) begin
      mismatches++;
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    int a, b, v, nshort, last_short;
    logic [7:0] s;
    srst_i = 1'b1;
    wb_req = '0;
    repeat (20) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    wb(0, `ADR_ADJ, {24'h0, `ADJ_RST}, 32'hffff_ffff);
    wb(0, `ADR_STAT, 32'h9, 32'h9);
    $display("test reset values done");
    for (int k = 0; k < 10; k++) begin
      case (k)
        0: s = 8'h02;
        1: s = 8'hfc;
        2: s = pack_set(7'(128 - 22), 1'b0);
        3: s = pack_set(7'(26 + 1), 1'b0);
        default: s = 8'(xs());
      endcase
      wb(1, `ADR_ADJ, {24'h0, s});
      wb(0, `ADR_ADJ, {24'h0, s}, 32'hffff_ffff);
      wb(0, `ADR_STAT, {16'h0, steps_of(s), 8'h0}, 32'h0000_ff00);
    end
    wb(1, 8'h10, 32'h0000_00ff);
    wb(0, 8'h10, 32'h0, 32'hffff_ffff);
    wb(0, `ADR_ADJ, {24'h0, s}, 32'hffff_ffff);
    $display("test setting decode done");
    wb(1, `ADR_ADJ, {24'h0, pack_set(7'd5, 1'b0)});
    until_lvl(1, 3000, a);
    until_lvl(0, 3000, a);
    until_lvl(1, 3000, a);
    chk_rng(a, CPS / 2, CPS / 2, "low half");
    until_lvl(0, 3000, b);
    nshort = 0;
    last_short = 0;
    for (int k = 1; k <= 62; k++) begin
      until_lvl(1, 3000, a);
      until_lvl(0, 3000, b);
      if (a + b != CPS) begin
        chk_rng(a + b, CPS - 40, CPS - 40, "short second");
        if (nshort > 0) chk_rng(k - last_short, 20, 20, "interval");
        nshort++;
        last_short = k;
      end
    end
    chk_rng(nshort, 2, 3, "short count");
    $display("test correction done");
    wb(1, `ADR_STAT, 32'h1);
    wb(1, `ADR_ADJ, 32'h0);
    wb(0, `ADR_STAT, 32'h0, 32'h1);
    until_lvl(0, 1200, a);
    chk_rng(a, 1200, 1200, "no 1 Hz");
    $display("test flag clear done");
    for (int k = 0; k < 3; k++) begin
      wb(1, `ADR_CTRL, k == 2 ? 32'h3 : 32'h1);
      wb(1, `ADR_SEC, k == 1 ? 32'd58 : 32'd59);
      wb(0, `ADR_SEC, k == 1 ? 32'd58 : 32'd59, 32'hffff_ffff);
      until_lvl(0, 4000, a);
      v = (k == 1 ? 2 : 1) * CPS + (k == 2 ? CPS / 2 : 0);
      chk_rng(a, v - 48, v + 8, "pulse delay");
      until_lvl(1, 100, b);
      chk_rng(b, PW, PW + 1, "pulse width");
    end
    wb(1, `ADR_CTRL, 32'h0);
    $display("test minute pulse done");
    report_and_stop();
  end
endmodule : tb_top
